// ---- cascaded_16bit_timer_pwm_bench.sv ----
// self-checking bench for the cascaded timer/pwm block
`timescale 1ns/1ps
`include "ctp_consts.vh"
module cascaded_16bit_timer_pwm_bench;
   localparam LOWF = 4; // short low-frequency divider for simulation
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h00000000;
   reg slow_clock_mode = 1'b0;
   reg ev_go = 1'b0; // starts a burst of count edges
   reg [7:0] ev_n = 8'h00; // falling edges in the burst
   reg [31:0] rd; // read data of the last transfer
   reg err; // error flag of the last transfer
   wire [31:0] prdata;
   wire pready, pslverr, event_input, pwm_out_n, match_irq, ev_busy;
   integer n_fail = 0;
   integer tests_run = 0;
   integer cyc = 0; // cycles since time zero
   integer n_irq = 0; // interrupt pulses seen
   integer i, c, t0;
   // pwm_out_n is watched right at the pin; no port latch sits between
   ctp_timer #(.LOWF_DIV(LOWF)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .event_input(event_input),
      .slow_clock_mode(slow_clock_mode), .pwm_out_n(pwm_out_n), .match_irq(match_irq));
   ctp_event_src u_src (.pclk(pclk), .go(ev_go), .n(ev_n), .event_input(event_input),
      .busy(ev_busy));
   always #12.5 pclk = ~pclk;
   // cycle count, interrupt tally and hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (match_irq === 1'b1)
         n_irq <= n_irq + 1;
      if (cyc == 100000)
      begin
         n_fail = n_fail + 1;
         $display("MISMATCH %0t timeout", $time);
         wrap_up;
      end
   end
   task wrap_up;
   begin
      if (n_fail == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
   begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   // one apb transfer; request held until pready is sampled high
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   end
   endtask
   // cycles from the next edge until an interrupt pulse
   task wait_irq;
   begin
      @(posedge pclk);
      for (c = 1; c < 70000 && match_irq !== 1'b1; c = c + 1)
         @(posedge pclk);
      chk(match_irq, 1);
   end
   endtask
   task reset_dut;
   begin
      presetn <= 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   end
   endtask
   // every register reads zero after reset; unmapped place refused
   task t_reset;
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         apb(1'b0, {i[9:0], 2'b00}, 32'h0);
         chk(rd, 32'h0);
      end
      chk(pwm_out_n, 1);
      apb(1'b0, 12'h020, 32'h0);
      chk(err, 1);
      chk(rd, 0);
   end
   endtask
   // interval between two matches is period times tap divide
   task t_timer(input [2:0] clk, input tap, input [15:0] p, input [31:0] div);
   begin
      apb(1'b1, `CTP_ADDR_LO_CTRL, {25'h0, clk, 1'b0, `CTP_LO_MODE_CASC});
      apb(1'b1, `CTP_ADDR_PERIOD_LO, {24'h0, p[7:0]});
      apb(1'b1, `CTP_ADDR_PERIOD_HI, {24'h0, p[15:8]});
      apb(1'b1, `CTP_ADDR_HI_CTRL, {23'h0, tap, 4'h0, 1'b1, `CTP_HI_MODE_TIMER});
      wait_irq;
      wait_irq;
      chk(c, p * div);
      apb(1'b1, `CTP_ADDR_HI_CTRL, {29'h0, `CTP_HI_MODE_TIMER});
      apb(1'b0, `CTP_ADDR_COUNT, 32'h0);
      t0 = rd;
      repeat (40) @(posedge pclk);
      apb(1'b0, `CTP_ADDR_COUNT, 32'h0);
      chk(rd, t0);
   end
   endtask
   // pwm-only sources and fast taps in slow mode leave a timer in place
   task t_gate;
   begin
      apb(1'b1, `CTP_ADDR_LO_CTRL, {25'h0, `CTP_CLK_LOWF, 1'b0, `CTP_LO_MODE_CASC});
      apb(1'b1, `CTP_ADDR_HI_CTRL, {28'h0, 1'b1, `CTP_HI_MODE_TIMER});
      apb(1'b0, `CTP_ADDR_COUNT, 32'h0);
      t0 = rd;
      repeat (64) @(posedge pclk);
      apb(1'b0, `CTP_ADDR_COUNT, 32'h0);
      chk(rd, t0);
      slow_clock_mode <= 1'b1;
      apb(1'b1, `CTP_ADDR_LO_CTRL, {25'h0, `CTP_CLK_D3, 1'b0, `CTP_LO_MODE_CASC});
      repeat (64) @(posedge pclk);
      apb(1'b0, `CTP_ADDR_COUNT, 32'h0);
      chk(rd, t0);
      slow_clock_mode <= 1'b0;
   end
   endtask
   // falling edges counted; a match clears and counting resumes
   task t_event;
   begin
      reset_dut;
      apb(1'b1, `CTP_ADDR_PERIOD_LO, 32'h3);
      apb(1'b1, `CTP_ADDR_PERIOD_HI, 32'h0);
      apb(1'b1, `CTP_ADDR_LO_CTRL, {25'h0, `CTP_CLK_EXT, 1'b0, `CTP_LO_MODE_CASC});
      apb(1'b1, `CTP_ADDR_HI_CTRL, {28'h0, 1'b1, `CTP_HI_MODE_TIMER});
      t0 = n_irq;
      ev_n <= 8'd5;
      ev_go <= 1'b1;
      @(posedge pclk);
      ev_go <= 1'b0;
      @(posedge pclk);
      for (c = 0; c < 200 && ev_busy; c = c + 1)
         @(posedge pclk);
      chk(ev_busy, 0);
      chk(n_irq - t0, 1);
      apb(1'b0, `CTP_ADDR_COUNT, 32'h0);
      chk(rd, 2);
   end
   endtask
   // duty toggle, full period, double buffer, stop hold and preset
   task t_pwm;
   begin
      reset_dut;
      apb(1'b1, `CTP_ADDR_LO_CTRL, {25'h0, `CTP_CLK_FULL, 1'b0, `CTP_LO_MODE_CASC});
      apb(1'b1, `CTP_ADDR_HI_CTRL, {29'h0, `CTP_HI_MODE_PWM});
      apb(1'b1, `CTP_ADDR_DUTY_LO, 32'h0);
      apb(1'b1, `CTP_ADDR_DUTY_HI, 32'h1);
      apb(1'b0, `CTP_ADDR_DUTY_HI, 32'h0);
      chk(rd, 1);
      apb(1'b1, `CTP_ADDR_HI_CTRL, {28'h0, 1'b1, `CTP_HI_MODE_PWM});
      t0 = cyc;
      for (c = 0; c < 400 && pwm_out_n !== 1'b0; c = c + 1)
         @(posedge pclk);
      chk(cyc - t0 > 250 && cyc - t0 < 262, 1);
      apb(1'b1, `CTP_ADDR_DUTY_LO, 32'h0);
      apb(1'b1, `CTP_ADDR_DUTY_HI, 32'h2);
      apb(1'b0, `CTP_ADDR_DUTY_HI, 32'h0);
      chk(rd, 1);
      wait_irq;
      chk(cyc - t0 > 65530 && cyc - t0 < 65542, 1);
      repeat (2) @(posedge pclk);
      chk(pwm_out_n, 1);
      apb(1'b0, `CTP_ADDR_DUTY_HI, 32'h0);
      chk(rd, 2);
      apb(1'b1, `CTP_ADDR_HI_CTRL, {24'h0, 1'b1, 4'h0, `CTP_HI_MODE_PWM});
      repeat (8) @(posedge pclk);
      chk(pwm_out_n, 1);
      apb(1'b1, `CTP_ADDR_HI_CTRL, {24'h0, 1'b1, 4'h0, `CTP_HI_MODE_PWM});
      repeat (2) @(posedge pclk);
      apb(1'b0, `CTP_ADDR_STATUS, 32'h0);
      chk({rd[1], pwm_out_n}, 2'b10);
   end
   endtask
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_timer(`CTP_CLK_SLOW, 1'b0, 16'h0001, 2048);
      t_timer(`CTP_CLK_D7, 1'b0, 16'h0005, 128);
      t_timer(`CTP_CLK_D5, 1'b0, 16'h0005, 32);
      slow_clock_mode <= 1'b1;
      t_timer(`CTP_CLK_SLOW, 1'b1, 16'h0005, LOWF * 8);
      slow_clock_mode <= 1'b0;
      t_timer(`CTP_CLK_D3, 1'b0, 16'h0101, 8);
      t_gate;
      t_event;
      t_pwm;
      wrap_up;
   end
endmodule // cascaded_16bit_timer_pwm_bench

// ---- ctp_consts.vh ----
// constants for the cascaded 16-bit timer/pwm block
`ifndef CTP_CONSTS_VH
`define CTP_CONSTS_VH
// ***************************************************
// register byte addresses
// ***************************************************
`define CTP_ADDR_LO_CTRL 12'h000
`define CTP_ADDR_HI_CTRL 12'h004
`define CTP_ADDR_PERIOD_LO 12'h008
`define CTP_ADDR_PERIOD_HI 12'h00C
`define CTP_ADDR_DUTY_LO 12'h010
`define CTP_ADDR_DUTY_HI 12'h014
`define CTP_ADDR_STATUS 12'h018
`define CTP_ADDR_COUNT 12'h01C
// ***************************************************
// control fields
// ***************************************************
`define CTP_LO_CLK_POS 4
`define CTP_LO_CLK_W 3
`define CTP_LO_MODE_POS 0
`define CTP_HI_MODE_POS 0
`define CTP_MODE_W 3
`define CTP_HI_RUN_POS 3
`define CTP_HI_FF_POS 7
`define CTP_HI_TAP_POS 8
// ***************************************************
// mode and clock codes
// ***************************************************
`define CTP_LO_MODE_CASC 3'h3
`define CTP_HI_MODE_TIMER 3'h4
`define CTP_HI_MODE_PWM 3'h6
`define CTP_CLK_SLOW 3'h0
`define CTP_CLK_D7 3'h1
`define CTP_CLK_D5 3'h2
`define CTP_CLK_D3 3'h3
`define CTP_CLK_LOWF 3'h4
`define CTP_CLK_HALF 3'h5
`define CTP_CLK_FULL 3'h6
`define CTP_CLK_EXT 3'h7
// ***************************************************
// reset values and timing
// ***************************************************
`define CTP_RST_BYTE 8'h00
`define CTP_RST_WORD 16'h0000
`define CTP_LOWF_DIV 16'd1220
`define CTP_PRE_W 11
`endif

// ---- ctp_event_src.sv ----
// behavioural source of count edges on the external pin
`timescale 1ns/1ps
module ctp_event_src #(
   parameter HOLD = 4
)(
   input wire pclk,
   input wire go,
   input wire [7:0] n,
   output reg event_input = 1'b1, // pin idles high, as a pulled-up input would
   output reg busy = 1'b0
);
   integer left = 0; // level changes still to make
   integer held = 0; // cycles the present level has stood
   always @(posedge pclk)
   begin
      if (go && !busy)
      begin
         left <= 2 * n;
         held <= 0;
         busy <= 1'b1;
      end
      else if (busy && held < HOLD - 1)
         held <= held + 1;
      else if (busy)
      begin
         held <= 0;
         if (left == 0)
            busy <= 1'b0;
         else
            event_input <= ~event_input;
         left <= left - 1;
      end
   end
endmodule // ctp_event_src

// ---- ctp_prescaler.v ----
// prescaler producing one-cycle tick enables for the timer source clocks
`timescale 1ns/1ps
module ctp_prescaler #(
   parameter LOWF_DIV = 1220
)(
   input wire pclk,
   input wire presetn,
   output reg tick_full,
   output reg tick_half,
   output reg tick_d3,
   output reg tick_d5,
   output reg tick_d7,
   output reg tick_d11,
   output reg tick_lowf,
   output reg tick_lowf_d3
);
   // free running divide chain; main clock stands in for the high clock
   reg [10:0] div_q;
   // low-frequency clock made from the main clock, since there is one clock
   reg [15:0] lowf_q;
   reg [2:0] lowf_div_q;
   wire lowf_wrap;
   assign lowf_wrap = (lowf_q == LOWF_DIV[15:0] - 16'd1);
   // ***************************************************
   // divider chain and tick enables
   // ***************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_q <= 11'h000;
         lowf_q <= 16'h0000;
         lowf_div_q <= 3'h0;
         tick_full <= 1'b0;
         tick_half <= 1'b0;
         tick_d3 <= 1'b0;
         tick_d5 <= 1'b0;
         tick_d7 <= 1'b0;
         tick_d11 <= 1'b0;
         tick_lowf <= 1'b0;
         tick_lowf_d3 <= 1'b0;
      end
      else
      begin
         div_q <= div_q + 11'h001;
         lowf_q <= lowf_wrap ? 16'h0000 : lowf_q + 16'h0001;
         if (lowf_wrap)
         begin
            lowf_div_q <= lowf_div_q + 3'h1;
         end
         // a tick fires when the lower bits of the chain all roll over
         tick_full <= 1'b1;
         tick_half <= div_q[0];
         tick_d3 <= &div_q[2:0];
         tick_d5 <= &div_q[4:0];
         tick_d7 <= &div_q[6:0];
         tick_d11 <= &div_q[10:0];
         tick_lowf <= lowf_wrap;
         tick_lowf_d3 <= lowf_wrap & (&lowf_div_q);
      end
   end
endmodule // ctp_prescaler

// ---- ctp_timer.v ----
// cascaded 16-bit timer, event counter and pwm unit with apb registers
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "ctp_consts.vh"
module ctp_timer #(
   parameter LOWF_DIV = 1220
)(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire event_input,
   input wire slow_clock_mode,
   output reg pwm_out_n,
   output reg match_irq
);
   // ***************************************************
   // registers and state
   // ***************************************************
   reg [7:0] lower_stage_ctrl_q; // clock select and lower mode
   reg [8:0] upper_stage_ctrl_q; // tap select, preset, run, upper mode
   reg [7:0] period_value_lo_q; // period low byte
   reg [7:0] period_value_hi_q; // period high byte
   reg [15:0] duty_active_q; // duty in use by the comparator
   reg [15:0] duty_stage_q; // duty staged by software
   reg duty_pend_q; // staged duty waits for the next irq
   reg [15:0] count_q; // cascaded up-counter
   reg out_ff_q; // output flip-flop
   reg event_q; // last sampled event_input level
   reg irq_seen_q; // sticky copy of match_irq for status reads
   wire tick_full;
   wire tick_half;
   wire tick_d3;
   wire tick_d5;
   wire tick_d7;
   wire tick_d11;
   wire tick_lowf;
   wire tick_lowf_d3;
   // ***************************************************
   // prescaler
   // ***************************************************
   ctp_prescaler #(
      .LOWF_DIV(LOWF_DIV)
   ) u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .tick_full(tick_full),
      .tick_half(tick_half),
      .tick_d3(tick_d3),
      .tick_d5(tick_d5),
      .tick_d7(tick_d7),
      .tick_d11(tick_d11),
      .tick_lowf(tick_lowf),
      .tick_lowf_d3(tick_lowf_d3)
   );
   // ***************************************************
   // mode decode
   // ***************************************************
   wire [2:0] lo_mode;
   wire [2:0] hi_mode;
   wire [2:0] clk_sel;
   wire run;
   wire tap_sel;
   wire cascaded;
   wire mode_timer;
   wire mode_pwm;
   wire mode_event;
   assign lo_mode = lower_stage_ctrl_q[`CTP_LO_MODE_POS +: `CTP_MODE_W];
   assign hi_mode = upper_stage_ctrl_q[`CTP_HI_MODE_POS +: `CTP_MODE_W];
   assign clk_sel = lower_stage_ctrl_q[`CTP_LO_CLK_POS +: `CTP_LO_CLK_W];
   assign run = upper_stage_ctrl_q[`CTP_HI_RUN_POS];
   assign tap_sel = upper_stage_ctrl_q[`CTP_HI_TAP_POS];
   assign cascaded = (lo_mode == `CTP_LO_MODE_CASC);
   assign mode_timer = cascaded && (hi_mode == `CTP_HI_MODE_TIMER)
      && (clk_sel != `CTP_CLK_EXT);
   // event counting is timer mode fed by the external pin
   assign mode_event = cascaded && (hi_mode == `CTP_HI_MODE_TIMER)
      && (clk_sel == `CTP_CLK_EXT);
   assign mode_pwm = cascaded && (hi_mode == `CTP_HI_MODE_PWM);
   // ***************************************************
   // source clock select
   // ***************************************************
   // event_q resets high like the idle pin, so reset makes no false fall
   // falling edge
   wire event_fall;
   assign event_fall = event_q & ~event_input;
   // limitation: in slow mode the fast-clock taps give no ticks at all
   reg src_tick;
   always @*
   begin
      case (clk_sel)
         `CTP_CLK_SLOW: src_tick = (tap_sel || slow_clock_mode) ? tick_lowf_d3 : tick_d11;
         `CTP_CLK_D7: src_tick = tick_d7 & ~slow_clock_mode;
         `CTP_CLK_D5: src_tick = tick_d5 & ~slow_clock_mode;
         `CTP_CLK_D3: src_tick = tick_d3 & ~slow_clock_mode;
         `CTP_CLK_LOWF: src_tick = mode_pwm & tick_lowf;
         `CTP_CLK_HALF: src_tick = mode_pwm & tick_half & ~slow_clock_mode;
         `CTP_CLK_FULL: src_tick = mode_pwm & tick_full & ~slow_clock_mode;
         `CTP_CLK_EXT: src_tick = event_fall;
         default: src_tick = 1'b0;
      endcase
   end
   // ***************************************************
   // counter events
   // ***************************************************
   wire [15:0] period;
   wire step;
   wire period_hit;
   wire duty_hit;
   wire overflow;
   wire cycle_end;
   assign period = {period_value_hi_q, period_value_lo_q};
   assign step = run && src_tick && (mode_timer || mode_event || mode_pwm);
   // live period
   // the hit is taken on the tick that would reach the period, so one
   // interval is exactly period ticks; a period of zero gives 65536 ticks
   assign period_hit = (mode_timer || mode_event) && step
      && (count_q + 16'h0001 == period);
   assign duty_hit = mode_pwm && step && (count_q == duty_active_q);
   assign overflow = mode_pwm && step && (count_q == 16'hFFFF);
   assign cycle_end = period_hit || overflow;
   // ***************************************************
   // apb decode
   // ***************************************************
   wire acc;
   wire wr;
   wire known;
   assign acc = psel && penable;
   assign wr = acc && pwrite;
   // unaligned or unlisted addresses are refused with pslverr
   assign known = (paddr == `CTP_ADDR_LO_CTRL) || (paddr == `CTP_ADDR_HI_CTRL)
      || (paddr == `CTP_ADDR_PERIOD_LO) || (paddr == `CTP_ADDR_PERIOD_HI)
      || (paddr == `CTP_ADDR_DUTY_LO) || (paddr == `CTP_ADDR_DUTY_HI)
      || (paddr == `CTP_ADDR_STATUS) || (paddr == `CTP_ADDR_COUNT);
   wire wr_hi_ctrl;
   wire wr_duty_lo;
   wire wr_duty_hi;
   wire ff_write;
   assign wr_hi_ctrl = wr && (paddr == `CTP_ADDR_HI_CTRL);
   assign wr_duty_lo = wr && (paddr == `CTP_ADDR_DUTY_LO);
   assign wr_duty_hi = wr && (paddr == `CTP_ADDR_DUTY_HI);
   // preset only when the write does not itself stop a running timer
   // no preset on stop
   assign ff_write = wr_hi_ctrl && !(run && !pwdata[`CTP_HI_RUN_POS]);
   // ***************************************************
   // control and period registers
   // ***************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lower_stage_ctrl_q <= `CTP_RST_BYTE;
         upper_stage_ctrl_q <= 9'h000;
         period_value_lo_q <= `CTP_RST_BYTE;
         period_value_hi_q <= `CTP_RST_BYTE;
      end
      else if (wr)
      begin
         case (paddr)
            `CTP_ADDR_LO_CTRL: lower_stage_ctrl_q <= pwdata[7:0];
            `CTP_ADDR_HI_CTRL: upper_stage_ctrl_q <= pwdata[8:0];
            `CTP_ADDR_PERIOD_LO: period_value_lo_q <= pwdata[7:0];
            `CTP_ADDR_PERIOD_HI: period_value_hi_q <= pwdata[7:0];
            // status and count are read-only; writes there are dropped
            default: lower_stage_ctrl_q <= lower_stage_ctrl_q;
         endcase
      end
   end
   // ***************************************************
   // duty double buffer
   // ***************************************************
   // the low byte always stages; the high byte write completes the pair
   // limitation: a lone low-byte write while running never goes live
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         duty_stage_q <= `CTP_RST_WORD;
         duty_active_q <= `CTP_RST_WORD;
         duty_pend_q <= 1'b0;
      end
      else
      begin
         if (wr_duty_lo)
         begin
            duty_stage_q[7:0] <= pwdata[7:0];
         end
         if (wr_duty_hi)
         begin
            duty_stage_q[15:8] <= pwdata[7:0];
         end
         if (!(run && mode_pwm) && (wr_duty_lo || wr_duty_hi))
         begin
            duty_active_q <= wr_duty_hi ? {pwdata[7:0], duty_stage_q[7:0]}
               : {duty_active_q[15:8], pwdata[7:0]};
            duty_pend_q <= 1'b0;
         end
         else if (overflow && (duty_pend_q || wr_duty_hi))
         begin
            // a write landing on the irq cycle may move a mixed value
            duty_active_q <= wr_duty_hi ? {pwdata[7:0], duty_stage_q[7:0]} : duty_stage_q;
            duty_pend_q <= 1'b0;
         end
         else if (wr_duty_hi)
         begin
            duty_pend_q <= 1'b1;
         end
      end
   end
   // ***************************************************
   // counter, output ff, irq
   // ***************************************************
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_q <= `CTP_RST_WORD;
         event_q <= 1'b1;
         out_ff_q <= 1'b0;
         pwm_out_n <= 1'b1;
         match_irq <= 1'b0;
         irq_seen_q <= 1'b0;
      end
      else
      begin
         event_q <= event_input;
         match_irq <= cycle_end;
         // a cleared count restarts from zero at the next source tick
         // clear then recount
         if (cycle_end)
         begin
            count_q <= `CTP_RST_WORD;
         end
         else if (step)
         begin
            count_q <= count_q + 16'h0001;
         end
         if (ff_write)
         begin
            out_ff_q <= pwdata[`CTP_HI_FF_POS];
            pwm_out_n <= ~pwdata[`CTP_HI_FF_POS];
         end
         else if (duty_hit != overflow)
         begin
            out_ff_q <= ~out_ff_q;
            pwm_out_n <= out_ff_q;
         end
         else
         begin
            pwm_out_n <= ~out_ff_q;
         end
         // set wins over a status read that clears
         if (cycle_end)
         begin
            irq_seen_q <= 1'b1;
         end
         else if (acc && !pwrite && (paddr == `CTP_ADDR_STATUS))
         begin
            irq_seen_q <= 1'b0;
         end
      end
   end
   // ***************************************************
   // apb read and response
   // ***************************************************
   reg [31:0] rd_d;
   always @*
   begin
      rd_d = 32'h00000000;
      case (paddr)
         `CTP_ADDR_LO_CTRL: rd_d[7:0] = lower_stage_ctrl_q;
         `CTP_ADDR_HI_CTRL: rd_d[8:0] = upper_stage_ctrl_q;
         `CTP_ADDR_PERIOD_LO: rd_d[7:0] = period_value_lo_q;
         `CTP_ADDR_PERIOD_HI: rd_d[7:0] = period_value_hi_q;
         `CTP_ADDR_DUTY_LO: rd_d[7:0] = duty_active_q[7:0];
         `CTP_ADDR_DUTY_HI: rd_d[7:0] = duty_active_q[15:8];
         `CTP_ADDR_STATUS: rd_d[2:0] = {duty_pend_q, out_ff_q, irq_seen_q};
         `CTP_ADDR_COUNT: rd_d[15:0] = count_q;
         default: rd_d = 32'h00000000;
      endcase
   end
   // no wait state: ready rises in the first access cycle
   // prdata is zero outside the answer so stale data never leaks
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !known;
         prdata <= (psel && !penable && !pwrite) ? rd_d : 32'h00000000;
      end
   end
endmodule // ctp_timer

// ---- ctp_timer_monitor.sv ----
// assertion checker for the cascaded timer/pwm block
`timescale 1ns/1ps
`include "ctp_consts.vh"
module ctp_timer_monitor #(
   parameter LOWF_DIV = 1220
)(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire event_input,
   input wire slow_clock_mode,
   input wire pwm_out_n,
   input wire match_irq
);
   // ******************
   // helper state
   // ******************
   wire wr_hi; // completed write to the upper control register
   reg run_q; // run bit as software last wrote it
   reg seen_q; // an upper control write since reset
   reg [1:0] quiet_q; // stopped cycles with no control write, saturating
   assign wr_hi = psel && penable && pready && pwrite && (paddr == `CTP_ADDR_HI_CTRL);
   // the quiet count lets the registered output settle before it is judged
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_q <= 1'b0;
         seen_q <= 1'b0;
         quiet_q <= 2'd0;
      end
      else
      begin
         if (wr_hi)
            run_q <= pwdata[`CTP_HI_RUN_POS];
         seen_q <= seen_q | wr_hi;
         if (wr_hi || run_q)
            quiet_q <= 2'd0;
         else if (quiet_q != 2'd3)
            quiet_q <= quiet_q + 2'd1;
      end
   end
   // ******************
   // properties
   // ******************
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_answer: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   chk_ready_cause: assert property (pready |-> penable && $past(psel && !penable))
      else $error("answer without setup");
   chk_err_unmapped: assert property (pslverr |-> pready
      && (paddr > 12'h01C || paddr[1:0] != 2'h0))
      else $error("error flag on mapped place");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   chk_irq_pulse: assert property (match_irq |=> !match_irq)
      else $error("interrupt longer than one cycle");
   chk_irq_stopped: assert property (quiet_q == 2'd3 |-> !match_irq)
      else $error("interrupt while stopped");
   chk_stop_hold: assert property (quiet_q == 2'd3 |-> $stable(pwm_out_n))
      else $error("output moved while stopped");
   chk_reset_level: assert property (!seen_q |-> pwm_out_n)
      else $error("output low before any preset");
   cover property (match_irq);
   cover property (pslverr);
   cover property ($fell(pwm_out_n));
   cover property (quiet_q == 2'd3 && !pwm_out_n);
endmodule // ctp_timer_monitor
bind ctp_timer ctp_timer_monitor #(.LOWF_DIV(LOWF_DIV)) u_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_input(event_input),
   .slow_clock_mode(slow_clock_mode), .pwm_out_n(pwm_out_n), .match_irq(match_irq));
